// ===== logic/pulse_output_pkg.sv
package pulse_output_pkg;

	// widths
	localparam int         ENERGY_W        = 32;
	localparam int         CFG_W           = 16;

	// register byte offsets
	localparam logic [7:0] OFS_CONFIG      = 8'h00;
	localparam logic [7:0] OFS_CAPTURE1    = 8'h04;
	localparam logic [7:0] OFS_CAPTURE2    = 8'h08;
	localparam logic [7:0] OFS_CAPTURE3    = 8'h0C;
	localparam logic [7:0] OFS_STATUS      = 8'h10;

	// config field positions
	localparam int         SRC3_LSB        = 6;
	localparam int         SRC3_MSB        = 8;
	localparam int         BIT_PIN1_DIS    = 9;
	localparam int         BIT_PIN2_DIS    = 10;
	localparam int         BIT_PIN3_DIS    = 11;
	localparam int         BIT_CAP1_EN     = 12;
	localparam int         BIT_CAP2_EN     = 13;
	localparam int         BIT_CAP3_EN     = 14;
	localparam int         BIT_RESERVED    = 15;

	// config reset value and writable bits
	localparam logic [15:0] CONFIG_RESET   = 16'h0E00;
	localparam logic [15:0] CONFIG_WMASK   = 16'h7FFF;

	// lowest reserved code of the third source select
	localparam logic [2:0] SRC3_RESERVED_MIN = 3'h5;

	// status field positions
	localparam int         STAT_PIN_LSB    = 0;
	localparam int         STAT_SUPPRESS3  = 3;

	// ahb transfer type bit that marks nonseq or seq
	localparam int         HTRANS_ACTIVE   = 1;

endpackage

// ===== logic/pulse_path_if.sv
`timescale 1ns/10ps
interface pulse_path_if #(
	parameter int EW = 32
);
	logic          strobe;
	logic [EW-1:0] energy;
	logic          pin_disable;
	logic          capture_en;
	logic          suppress;
	logic          pin_out;
	logic [EW-1:0] captured;

	modport ctrl (
		output strobe,
		output energy,
		output pin_disable,
		output capture_en,
		output suppress,
		input  pin_out,
		input  captured
	);

	modport path (
		input  strobe,
		input  energy,
		input  pin_disable,
		input  capture_en,
		input  suppress,
		output pin_out,
		output captured
	);
endinterface

// ===== logic/pulse_path_unit.sv
`timescale 1ns/10ps
module pulse_path_unit
	import pulse_output_pkg::*;
#(
	parameter int EW = ENERGY_W
)(
	input  wire logic   hclk,
	input  wire logic   hresetn,
	pulse_path_if.path  pp
);
	logic          pin_ff;
	logic [EW-1:0] captured_ff;
	logic          nxt_pin;
	logic          do_capture;

	// pin only sees the strobe when neither disabled nor suppressed
	assign nxt_pin    = pp.strobe & ~pp.pin_disable & ~pp.suppress;
	// capture ignores the pin disable, the converter keeps running
	assign do_capture = pp.strobe & pp.capture_en & ~pp.suppress;

	// pin is registered so it never glitches on the strobe path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_ff <= 1'b0;
		end else begin
			pin_ff <= nxt_pin;
		end
	end

	// snapshot holds until the next enabled pulse of this path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			captured_ff <= '0;
		end else if (do_capture) begin
			captured_ff <= pp.energy;
		end
	end

	assign pp.pin_out  = pin_ff;
	assign pp.captured = captured_ff;
endmodule

// ===== logic/pulse_output_gate_latch_ctrl.sv
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module pulse_output_gate_latch_ctrl
	import pulse_output_pkg::*;
#(
	parameter int EW = ENERGY_W
)(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	input  wire logic [2:0]    conv_pulse,
	input  wire logic [EW-1:0] energy_first,
	input  wire logic [EW-1:0] energy_second,
	input  wire logic [EW-1:0] energy_third,
	output logic               pulse_out_first,
	output logic               pulse_out_second,
	output logic               pulse_out_third,
	output logic [8:0]         lower_select
);
	logic [CFG_W-1:0] cfg_ff;
	logic [7:0]       addr_ff;
	logic             wr_pend_ff;
	logic             rd_pend_ff;

	logic             addr_phase;
	logic             cfg_write;
	logic [2:0]       pin_disable;
	logic [2:0]       capture_en;
	logic [2:0]       pin_level;
	logic [2:0]       pulse3_source_select;
	logic             pulse3_suppressed;
	logic [EW-1:0]    energy_arr   [3];
	logic [EW-1:0]    captured_arr [3];
	logic [31:0]      rd_mux;

	// field decode of the mode register
	assign pin_disable = {cfg_ff[BIT_PIN3_DIS], cfg_ff[BIT_PIN2_DIS],
	                      cfg_ff[BIT_PIN1_DIS]};
	assign capture_en  = {cfg_ff[BIT_CAP3_EN], cfg_ff[BIT_CAP2_EN],
	                      cfg_ff[BIT_CAP1_EN]};
	assign pulse3_source_select = cfg_ff[SRC3_MSB:SRC3_LSB];
	assign pulse3_suppressed = (pulse3_source_select >= SRC3_RESERVED_MIN);
	assign lower_select = cfg_ff[SRC3_MSB:0];

	assign energy_arr[0] = energy_first;
	assign energy_arr[1] = energy_second;
	assign energy_arr[2] = energy_third;

	// one gate and capture unit per pulse path
	generate
		for (genvar i = 0; i < 3; i++) begin : g_path
			pulse_path_if #(.EW(EW)) pp ();
			assign pp.strobe      = conv_pulse[i];
			assign pp.energy      = energy_arr[i];
			assign pp.pin_disable = pin_disable[i];
			assign pp.capture_en  = capture_en[i];
			assign pp.suppress    = (i == 2) ? pulse3_suppressed : 1'b0;
			assign pin_level[i]   = pp.pin_out;
			assign captured_arr[i] = pp.captured;
			pulse_path_unit #(.EW(EW)) u_unit (
				.hclk    (hclk),
				.hresetn (hresetn),
				.pp      (pp.path)
			);
		end
	endgenerate

	assign pulse_out_first  = pin_level[0];
	assign pulse_out_second = pin_level[1];
	assign pulse_out_third  = pin_level[2];

	// bus side: zero wait states, always okay
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign addr_phase = hsel & hready & htrans[HTRANS_ACTIVE];
	assign cfg_write  = wr_pend_ff & (addr_ff == OFS_CONFIG);

	// address phase is latched, the data phase acts on it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_ff    <= 8'h00;
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
		end else if (hready) begin
			addr_ff    <= haddr[7:0];
			wr_pend_ff <= addr_phase & hwrite;
			rd_pend_ff <= addr_phase & ~hwrite;
		end
	end

	// reserved bit is masked so it can never hold a one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= CONFIG_RESET;
		end else if (cfg_write) begin
			cfg_ff <= hwdata[CFG_W-1:0] & CONFIG_WMASK;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_ff == OFS_CONFIG) begin
			rd_mux[CFG_W-1:0] = cfg_ff;
		end else if (addr_ff == OFS_CAPTURE1) begin
			rd_mux[EW-1:0] = captured_arr[0];
		end else if (addr_ff == OFS_CAPTURE2) begin
			rd_mux[EW-1:0] = captured_arr[1];
		end else if (addr_ff == OFS_CAPTURE3) begin
			rd_mux[EW-1:0] = captured_arr[2];
		end else if (addr_ff == OFS_STATUS) begin
			rd_mux[STAT_PIN_LSB +: 3] = pin_level;
			rd_mux[STAT_SUPPRESS3]    = pulse3_suppressed;
		end
	end

	// data taken straight from flops during the data phase
	assign hrdata = rd_pend_ff ? rd_mux : 32'h0000_0000;
endmodule

// ===== verif/pulse_output_properties.sv
`timescale 1ns/10ps
module pulse_output_props
	import pulse_output_pkg::*;
#(
	parameter int EW = ENERGY_W
)(
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire logic          hsel,
	input wire logic [31:0]   haddr,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic [31:0]   hwdata,
	input wire logic          hready,
	input wire logic [31:0]   hrdata,
	input wire logic          hreadyout,
	input wire logic          hresp,
	input wire logic [2:0]    conv_pulse,
	input wire logic [EW-1:0] energy_first,
	input wire logic [EW-1:0] energy_second,
	input wire logic [EW-1:0] energy_third,
	input wire logic          pulse_out_first,
	input wire logic          pulse_out_second,
	input wire logic          pulse_out_third,
	input wire logic [8:0]    lower_select
);
	// shadow of config and captures, rebuilt from what crosses the ports
	logic [15:0]   cfg_ff;
	logic [EW-1:0] cap_ff [3];
	logic          rd_ff, wr_ff;
	logic [7:0]    adr_ff;
	wire           take = hsel && hready && htrans[HTRANS_ACTIVE];
	wire           sup3 = cfg_ff[8:6] >= SRC3_RESERVED_MIN;
	wire [2:0]     cap_on = cfg_ff[14:12] & {!sup3, 2'b11};
	// captures start at zero; bench enables all paths before any capture read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= CONFIG_RESET;
			rd_ff  <= 1'b0;
			wr_ff  <= 1'b0;
			adr_ff <= 8'h00;
			cap_ff <= '{default: '0};
		end else begin
			rd_ff  <= take && !hwrite;
			wr_ff  <= take && hwrite && haddr[7:0] == OFS_CONFIG;
			adr_ff <= haddr[7:0];
			if (wr_ff)
				cfg_ff <= hwdata[15:0] & CONFIG_WMASK;
			if (conv_pulse[0] && cap_on[0])
				cap_ff[0] <= energy_first;
			if (conv_pulse[1] && cap_on[1])
				cap_ff[1] <= energy_second;
			if (conv_pulse[2] && cap_on[2])
				cap_ff[2] <= energy_third;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_pin_first_gate: assert property (pulse_out_first ==
		($past(conv_pulse[0]) && !$past(cfg_ff[9]))) else $error("pin one");
	a_pin_second_gate: assert property (pulse_out_second ==
		($past(conv_pulse[1]) && !$past(cfg_ff[10]))) else $error("pin two");
	a_pin_third_gate: assert property (pulse_out_third ==
		($past(conv_pulse[2]) && !$past(cfg_ff[11]) && !$past(sup3)))
		else $error("pin three");
	a_config_read: assert property (rd_ff && adr_ff == OFS_CONFIG
		|-> hrdata == {16'h0000, cfg_ff}) else $error("config read");
	a_capture_read: assert property (rd_ff && adr_ff[7:4] == 4'h0
		&& adr_ff[3:2] != 2'h0 && adr_ff[1:0] == 2'h0
		|-> hrdata == cap_ff[adr_ff[3:2] - 2'h1]) else $error("capture");
	a_suppress_flag: assert property (rd_ff && adr_ff == OFS_STATUS
		|-> hrdata[STAT_SUPPRESS3] == sup3) else $error("suppress flag");
	a_lower_select: assert property (lower_select == cfg_ff[8:0])
		else $error("lower select");
	a_idle_rdata: assert property (!rd_ff |-> hrdata == 32'h0000_0000)
		else $error("idle read data");
	// single slave with no wait states, so the answer is always ready
	a_bus_always_okay: assert property (hreadyout && !hresp)
		else $error("bus response");
	a_status_pins: assert property (rd_ff && adr_ff == OFS_STATUS
		|-> hrdata[2:0] == {pulse_out_third, pulse_out_second,
		pulse_out_first}) else $error("status pins");
endmodule
bind pulse_output_gate_latch_ctrl pulse_output_props #(.EW(EW)) i_props (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hreadyout, .hresp, .hrdata, .conv_pulse, .energy_first,
	.energy_second, .energy_third,
	.pulse_out_first, .pulse_out_second, .pulse_out_third, .lower_select);

// ===== verif/pulse_output_gate_latch_ctrl_test.sv
`timescale 1ns/10ps
module pulse_output_gate_latch_ctrl_test
	import pulse_output_pkg::*;
;
	logic        hclk = 0, hresetn = 0, hwrite = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, r, en [3] = '{default: 0}, cap [3];
	logic [2:0]  conv_pulse = 0;
	logic [15:0] c;
	wire         hreadyout, hresp, p1, p2, p3;
	wire  [31:0] hrdata;
	int          err_total = 0, compares = 0;
	// config written beside expected pins {third, second, first}
	logic [18:0] rows [6] = '{{16'h7000, 3'h7}, {16'hF140, 3'h3},
		{16'h71C0, 3'h3}, {16'h5310, 3'h6}, {16'h0E00, 3'h0},
		{16'h0C7F, 3'h1}};
	always #10 hclk = ~hclk;
	pulse_output_gate_latch_ctrl i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.conv_pulse(conv_pulse), .energy_first(en[0]),
		.energy_second(en[1]), .energy_third(en[2]),
		.pulse_out_first(p1), .pulse_out_second(p2),
		.pulse_out_third(p3), .lower_select());
	task report_and_stop;
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			err_total++;
			$display("CHECK FAILED %0t %h %h", $time, s, x);
		end
	endtask
	// single word transfer; read data taken at the data phase end
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	initial begin
		#100000;
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, OFS_CONFIG, 0);
		check(r, 32'h0E00);
		for (int k = 0; k < 6; k++) begin
			c = rows[k][18:3];
			bus(1, OFS_CONFIG, {16'h0, c});
			bus(0, OFS_CONFIG, 0);
			check(r, {16'h0, c & 16'h7FFF});
			@(posedge hclk);
			conv_pulse <= 3'h7;
			for (int i = 0; i < 3; i++)
				en[i] <= 32'hE000_0000 + 16 * k + i;
			@(posedge hclk);
			conv_pulse <= 3'h0;
			#1 check(32'({p3, p2, p1}), 32'(rows[k][2:0]));
			for (int i = 0; i < 3; i++) begin
				if (c[12 + i] && !(i == 2 && c[8:6] > 3'h4))
					cap[i] = en[i];
				bus(0, OFS_CAPTURE1 + 8'(4 * i), 0);
				check(r, cap[i]);
			end
			bus(0, OFS_STATUS, 0);
			check(32'(r[3]), 32'(c[8:6] > 3'h4));
		end
		// back-to-back strobes: the later capture wins
		bus(1, OFS_CONFIG, 32'h1000);
		@(posedge hclk);
		conv_pulse <= 3'h1;
		en[0]      <= 32'h1234_5678;
		@(posedge hclk);
		en[0]      <= 32'h8765_4321;
		@(posedge hclk);
		conv_pulse <= 3'h0;
		#1 check(32'(p1), 32'h1);
		bus(0, OFS_CAPTURE1, 0);
		check(r, 32'h8765_4321);
		bus(0, 8'h20, 0);
		check(r, 32'h0);
		// reset in mid-run restores the defaults
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		bus(0, OFS_CONFIG, 0);
		check(r, 32'h0E00);
		report_and_stop;
	end
endmodule
